//--- shared/dac_io_pkg.sv
// dac_io_pkg: constants, field positions and the decode helper for the
// converter i/o bus interface and its buffer bank.
// assumes a single pclk domain and a 32-bit apb slave for local settings.
package dac_io_pkg;

    // apb register map, byte addresses
    localparam logic [7:0]  OFF_DEV_ADDR   = 8'h00;   // device address, rw
    localparam logic [7:0]  OFF_STATUS     = 8'h04;   // block state, ro
    localparam int          APB_ADDR_W     = 8;       // decoded address bits

    // reset values
    localparam logic [5:0]  DEV_ADDR_RST   = 6'h28;   // octal 050
    localparam logic [2:0]  SEL_CODE_RST   = 3'h0;    // converter 0
    localparam logic [7:0]  EXT_CTRL_RST_N = 8'hff;   // all released

    // i/o bus fields
    localparam int          BUS_W          = 16;      // data word width
    localparam int          ADDR_LSB       = 0;       // device address lsb
    localparam int          ADDR_W         = 6;       // device address width
    localparam int          FCODE_LSB      = 6;       // function code lsb
    localparam int          FCODE_W        = 3;       // function code width
    localparam int          TAG_EXT_CTRL   = 11;      // external control tag
    localparam int          TAG_SENSE      = 12;      // sense tag
    localparam int          TAG_DATA_OUT   = 14;      // data transfer out tag
    localparam int          TAG_SELECT     = 15;      // converter select tag

    // converter count and line counts
    localparam int          NUM_CONV       = 8;       // converter buffers
    localparam int          NUM_EXT        = 8;       // control outputs
    localparam int          NUM_SENSE      = 8;       // sense inputs

    // status register field positions
    localparam int          ST_SEL_LSB     = 0;       // select code, 3 bits
    localparam int          ST_XFER_OUT    = 3;       // transfer out latch
    localparam int          ST_CONNECTED   = 4;       // connected latch
    localparam int          ST_XFER_EN     = 5;       // transfer enable
    localparam int          ST_XFER_REQ    = 6;       // transfer request
    localparam int          ST_EXT_LSB     = 8;       // control set bits, 8

    // one-of-eight decode, shared by select lines and control outputs
    function automatic logic [7:0] one_hot8(input logic [2:0] code);
        logic [7:0] v;
        v = 8'h00;
        v[code] = 1'b1;
        return v;
    endfunction

endpackage

//--- design/converter_buffer_bank.sv
// converter_buffer_bank: eight converter buffer registers and the
// one-of-eight select lines that steer the data strobe into one of them.
// assumes the strobe is a single-cycle pulse already qualified upstream.
`timescale 1ns/1ps
module converter_buffer_bank #(
    parameter int DATA_W = 16,
    parameter int NUM    = 8
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // load control
    input  wire logic [2:0]            sel_code,
    input  wire logic                  load_pulse,
    input  wire logic                  gate_en,
    input  wire logic [DATA_W-1:0]     data_in,
    // converter side
    output logic [NUM-1:0]             select_lines,
    output logic [NUM*DATA_W-1:0]      buffer_data
);

    // all state of the bank
    typedef struct packed {
        logic [NUM-1:0]        sel;    // registered select lines
        logic [NUM*DATA_W-1:0] buf_q;  // converter buffers
    } bank_state_t;

    bank_state_t state_r;   // registered state
    bank_state_t state_nxt; // next state

    // decode select and strobe the chosen buffer
    always_comb
    begin
        state_nxt = state_r;
        // the line stays up until another code arrives
        state_nxt.sel = dac_io_pkg::one_hot8(sel_code);
        // the strobe gate needs its second input: latch or enable
        if (load_pulse && gate_en)
        begin
            for (int i = 0; i < NUM; i++)
            begin
                if (state_r.sel[i])
                begin
                    state_nxt.buf_q[i*DATA_W +: DATA_W] = data_in;
                end
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign select_lines = state_r.sel;
    assign buffer_data  = state_r.buf_q;

endmodule // converter_buffer_bank

//--- design/converter_io_bus_interface.sv
// converter_io_bus_interface: i/o bus side of a master converter module.
// holds device decode, select code, transfer latches, controller
// handshake, external control flip-flops, sense mux and an apb slave.
// assumes every input is synchronous to pclk and strobes last >= 1 cycle.
`timescale 1ns/1ps
module converter_io_bus_interface #(
    parameter int DATA_W = 16,
    parameter int NUM    = 8
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // computer i/o bus
    input  wire logic [DATA_W-1:0]     io_bus,
    input  wire logic                  function_ready_strobe,
    input  wire logic                  data_ready_strobe,
    output logic                       sense_reply,
    // block transfer controller
    input  wire logic                  module_connect_enable,
    input  wire logic                  controller_connect_request,
    input  wire logic                  transfer_acknowledge,
    input  wire logic                  controller_disconnect,
    input  wire logic                  device_ready,
    output logic                       connected_acknowledge,
    output logic                       transfer_direction,
    output logic                       transfer_request,
    // external control and sense lines
    input  wire logic [NUM-1:0]        ext_ctrl_clear,
    input  wire logic [NUM-1:0]        sense_input_n,
    output logic [NUM-1:0]             external_control_output_n,
    // converter side
    output logic [NUM-1:0]             converter_select,
    output logic [NUM*DATA_W-1:0]      converter_data
);

    // all state of the interface
    typedef struct packed {
        logic                  fr_d;       // strobe level, last cycle
        logic                  dr_d;       // strobe level, last cycle
        logic [5:0]            dev_addr;   // address this module answers
        logic [2:0]            sel_code;   // converter select code
        logic                  xfer_out;   // transfer out latch
        logic                  connected;  // connected latch
        logic                  xfer_en;    // transfer enable
        logic                  xfer_req;   // request to controller
        logic [NUM-1:0]        ext_n;      // control outputs, low = set
        logic                  sense;      // sense answer to computer
        logic                  pready;     // apb answer
        logic                  pslverr;    // apb error
        logic [31:0]           prdata;     // apb read data
        logic                  load;       // one-cycle data strobe
        logic                  gate;       // strobe gate second input
        logic [DATA_W-1:0]     data_q;     // data word at the strobe
    } io_state_t;

    io_state_t state_r;    // registered state
    io_state_t state_nxt;  // next state

    // decoded bus terms, combinational
    logic                 addr_match;   // device address on the bus
    logic                 fr_rise;      // function strobe leading edge
    logic                 dr_rise;      // data strobe leading edge
    logic                 func_sel;     // qualified function select
    logic [2:0]           fcode;        // function code field
    logic [NUM-1:0]       fcode_hot;    // decoded function code
    logic                 apb_setup;    // access phase, not answered
    logic                 apb_done;     // access completes this edge
    logic [7:0]           apb_off;      // decoded byte offset
    logic                 apb_hit;      // mapped offset
    logic [31:0]          status_word;  // status register view

    // bus field decode; edges keep one action per strobe
    always_comb
    begin
        addr_match = (io_bus[dac_io_pkg::ADDR_LSB +: dac_io_pkg::ADDR_W]
                      == state_r.dev_addr);
        fr_rise    = function_ready_strobe && !state_r.fr_d;
        dr_rise    = data_ready_strobe && !state_r.dr_d;
        func_sel   = fr_rise && addr_match;
        fcode      = io_bus[dac_io_pkg::FCODE_LSB +: dac_io_pkg::FCODE_W];
        fcode_hot  = dac_io_pkg::one_hot8(fcode);
    end

    // apb decode; only the low byte of the address is decoded
    always_comb
    begin
        apb_off   = paddr[7:0];
        apb_setup = psel && penable && !state_r.pready;
        apb_done  = psel && penable && state_r.pready;
        apb_hit   = (apb_off == dac_io_pkg::OFF_DEV_ADDR) ||
                    (apb_off == dac_io_pkg::OFF_STATUS);
        status_word = 32'h0000_0000;
        status_word[dac_io_pkg::ST_SEL_LSB +: 3]  = state_r.sel_code;
        status_word[dac_io_pkg::ST_XFER_OUT]      = state_r.xfer_out;
        status_word[dac_io_pkg::ST_CONNECTED]     = state_r.connected;
        status_word[dac_io_pkg::ST_XFER_EN]       = state_r.xfer_en;
        status_word[dac_io_pkg::ST_XFER_REQ]      = state_r.xfer_req;
        status_word[dac_io_pkg::ST_EXT_LSB +: 8]  = ~state_r.ext_n;
    end

    // next-state logic for the whole interface
    always_comb
    begin
        state_nxt      = state_r;
        state_nxt.fr_d = function_ready_strobe;
        state_nxt.dr_d = data_ready_strobe;

        // select stage: code held until the next select instruction
        if (func_sel && io_bus[dac_io_pkg::TAG_SELECT])
        begin
            state_nxt.sel_code = fcode;
        end

        // program transfer: the data strobe consumes the latch
        if (dr_rise)
        begin
            state_nxt.xfer_out = 1'b0;
        end
        // a set in the same cycle as the clear wins
        if (func_sel && io_bus[dac_io_pkg::TAG_DATA_OUT])
        begin
            state_nxt.xfer_out = 1'b1;
        end

        // controller connection: disconnect ends the block
        if (controller_disconnect)
        begin
            state_nxt.connected = 1'b0;
        end
        // connect held even after the controller drops its request
        if (module_connect_enable && controller_connect_request)
        begin
            state_nxt.connected = 1'b1;
        end

        // transfer enable lasts from acknowledge to the data strobe
        if (dr_rise || !state_nxt.connected)
        begin
            state_nxt.xfer_en = 1'b0;
        end
        if (transfer_acknowledge && state_nxt.connected)
        begin
            state_nxt.xfer_en = 1'b1;
        end

        // request follows device ready while connected, masked while transfer enable is set
        state_nxt.xfer_req = state_nxt.connected && device_ready &&
                             !state_nxt.xfer_en;

        // control flip-flops: hardware clear, instruction set only
        for (int i = 0; i < NUM; i++)
        begin
            if (ext_ctrl_clear[i])
            begin
                state_nxt.ext_n[i] = 1'b1;
            end
        end
        // tag read only on the address strobe, set wins a clash
        if (func_sel && io_bus[dac_io_pkg::TAG_EXT_CTRL])
        begin
            state_nxt.ext_n = state_nxt.ext_n & ~fcode_hot;
        end

        // sense answer stands while the address strobe stays up
        state_nxt.sense = function_ready_strobe && addr_match &&
                          io_bus[dac_io_pkg::TAG_SENSE] &&
                          !sense_input_n[fcode];

        // data word captured on the strobe edge, word is on the bus
        state_nxt.load   = dr_rise;
        state_nxt.gate   = state_r.xfer_out || state_r.xfer_en;
        state_nxt.data_q = io_bus;

        // apb: one wait state, then the answer for one cycle
        state_nxt.pready  = apb_setup;
        state_nxt.pslverr = apb_setup && !apb_hit;
        state_nxt.prdata  = 32'h0000_0000;
        if (apb_setup && !pwrite)
        begin
            if (apb_off == dac_io_pkg::OFF_DEV_ADDR)
            begin
                state_nxt.prdata = {26'h0000000, state_r.dev_addr};
            end
            else if (apb_off == dac_io_pkg::OFF_STATUS)
            begin
                state_nxt.prdata = status_word;
            end
            else
            begin
                state_nxt.prdata = 32'h0000_0000; // unmapped reads zero
            end
        end
        // hold read data through the answer cycle
        if (state_r.pready && psel && penable)
        begin
            state_nxt.prdata = state_r.prdata;
        end
        // writes land on the edge where pready is sampled
        if (apb_done && pwrite && (apb_off == dac_io_pkg::OFF_DEV_ADDR))
        begin
            state_nxt.dev_addr = pwdata[5:0];
        end
        // the answer is a single cycle
        if (state_r.pready)
        begin
            state_nxt.pready  = 1'b0;
            state_nxt.pslverr = 1'b0;
        end
    end

    // state register; reset clears latches, code and controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r           <= '0;
            state_r.dev_addr  <= dac_io_pkg::DEV_ADDR_RST;
            state_r.sel_code  <= dac_io_pkg::SEL_CODE_RST;
            state_r.ext_n     <= dac_io_pkg::EXT_CTRL_RST_N;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // buffer bank; the strobe lags the bus edge by one cycle, which
    // costs nothing because the data word is already captured
    converter_buffer_bank #(
        .DATA_W (DATA_W),
        .NUM    (NUM)
    ) u_bank (
        .pclk         (pclk),
        .presetn      (presetn),
        .sel_code     (state_r.sel_code),
        .load_pulse   (state_r.load),
        .gate_en      (state_r.gate),
        .data_in      (state_r.data_q),
        .select_lines (converter_select),
        .buffer_data  (converter_data)
    );

    // outputs straight from the state register
    assign prdata                    = state_r.prdata;
    assign pready                    = state_r.pready;
    assign pslverr                   = state_r.pslverr;
    assign sense_reply               = state_r.sense;
    assign connected_acknowledge     = state_r.connected;
    assign transfer_direction        = state_r.connected;
    assign transfer_request          = state_r.xfer_req;
    // every control output reaches a pin, one may feed connect enable
    assign external_control_output_n = state_r.ext_n;

endmodule // converter_io_bus_interface

//--- bench/converter_io_bus_interface_asserts.sv
// checker: decode, select, handshake, control flops and sense at the ports
// assumes the device address register keeps its reset value
`timescale 1ns/1ps
module converter_io_bus_interface_asserts #(
    parameter int DATA_W = 16,
    parameter int NUM    = 8
) (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // computer bus
    input wire logic [DATA_W-1:0] io_bus,
    input wire logic              function_ready_strobe,
    input wire logic              sense_reply,
    input wire logic [NUM-1:0]    sense_input_n,
    // controller
    input wire logic              module_connect_enable,
    input wire logic              controller_connect_request,
    input wire logic              transfer_acknowledge,
    input wire logic              controller_disconnect,
    input wire logic              device_ready,
    input wire logic              connected_acknowledge,
    input wire logic              transfer_request,
    // control lines and converters
    input wire logic [NUM-1:0]    ext_ctrl_clear,
    input wire logic [NUM-1:0]    external_control_output_n,
    input wire logic [NUM-1:0]    converter_select
);
    logic       frs_r; // strobe last cycle
    logic [1:0] up_r;  // cycles since reset; outputs still settle before 3
    logic       me;    // our address on the bus
    logic       hit;   // strobe rise at our address
    assign me  = io_bus[5:0] == dac_io_pkg::DEV_ADDR_RST;
    assign hit = function_ready_strobe & ~frs_r & me;
    // edge detect and settle count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frs_r <= 1'h0;
            up_r  <= 2'h0;
        end
        else
        begin
            frs_r <= function_ready_strobe;
            up_r  <= up_r + {1'h0, ~&up_r};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence sel_s; hit && io_bus[15]; endsequence
    sequence ext_s; hit && io_bus[11]; endsequence
    sequence sense_s; function_ready_strobe && me && io_bus[12]; endsequence
    sel_load_a: assert property (sel_s |-> ##2 converter_select == NUM'(1) << $past(io_bus[8:6], 2))
        else $error("select not loaded");
    sel_hold_a: assert property (up_r == 2'h3 && !$past(hit && io_bus[15], 2) |-> $stable(converter_select))
        else $error("select moved");
    sel_onehot_a: assert property (up_r == 2'h3 |-> $onehot(converter_select))
        else $error("select not one-hot");
    conn_set_a: assert property (module_connect_enable && controller_connect_request |=> connected_acknowledge)
        else $error("no connect");
    conn_drop_a: assert property (controller_disconnect && !module_connect_enable |=> !connected_acknowledge)
        else $error("no disconnect");
    req_cause_a: assert property (transfer_request |-> connected_acknowledge && $past(device_ready))
        else $error("request without cause");
    req_drop_a: assert property (transfer_acknowledge && connected_acknowledge |-> ##2 !transfer_request)
        else $error("request not dropped");
    ext_set_a: assert property (ext_s |=> !external_control_output_n[$past(io_bus[8:6])])
        else $error("control line not set");
    ext_keep_a: assert property (up_r == 2'h3 |->
        (external_control_output_n & ~$past(external_control_output_n) & ~$past(ext_ctrl_clear)) == '0)
        else $error("control line released");
    sense_val_a: assert property (sense_s |=> sense_reply == !$past(sense_input_n[io_bus[8:6]]))
        else $error("sense reply wrong");
endmodule // converter_io_bus_interface_asserts
bind converter_io_bus_interface converter_io_bus_interface_asserts #(.DATA_W(DATA_W), .NUM(NUM)) i_asserts (.*);

//--- bench/bus_host_model.sv
// host bus and transfer controller model, driving strobes and handshake
// assumes a free-running pclk; tasks are entered at a rising edge
`timescale 1ns/1ps
module bus_host_model (
    // clock
    input wire logic    pclk,
    // computer bus
    output logic [15:0] io_bus,
    output logic        function_ready_strobe,
    output logic        data_ready_strobe,
    input wire logic    sense_reply,
    // controller
    output logic        module_connect_enable,
    output logic        controller_connect_request,
    output logic        transfer_acknowledge,
    output logic        controller_disconnect,
    output logic        device_ready,
    input wire logic    connected_acknowledge,
    input wire logic    transfer_request
);
    // idle at time zero
    initial
    begin
        io_bus = 16'h0000;
        {function_ready_strobe, data_ready_strobe, module_connect_enable} = 3'h0;
        {controller_connect_request, transfer_acknowledge, controller_disconnect, device_ready} = 4'h0;
    end
    // address, code and tags under a two-cycle strobe; sense reply returned
    task automatic instr(input logic [5:0] a, input logic [2:0] f, input logic [6:0] tags, output logic rep);
        io_bus <= {tags, f, a};
        function_ready_strobe <= 1'h1;
        repeat (2) @(posedge pclk);
        rep = sense_reply;
        function_ready_strobe <= 1'h0;
        @(posedge pclk);
        io_bus <= ~io_bus;
        @(posedge pclk);
    endtask
    // word then data strobe; a released bus shows the inverse, not the word
    task automatic word(input logic [15:0] d);
        io_bus <= d;
        @(posedge pclk);
        data_ready_strobe <= 1'h1;
        repeat (2) @(posedge pclk);
        data_ready_strobe <= 1'h0;
        io_bus <= ~d;
        @(posedge pclk);
    endtask
    // connect pair held until acknowledged, then withdrawn
    task automatic connect();
        module_connect_enable <= 1'h1;
        controller_connect_request <= 1'h1;
        while (connected_acknowledge !== 1'h1) @(posedge pclk);
        module_connect_enable <= 1'h0;
        controller_connect_request <= 1'h0;
        @(posedge pclk);
    endtask
    // one paced word: ready held until the request shows, then acknowledge
    task automatic paced(input logic [15:0] d);
        repeat (4) @(posedge pclk);
        device_ready <= 1'h1;
        @(posedge pclk);
        while (transfer_request !== 1'h1) @(posedge pclk);
        device_ready <= 1'h0;
        io_bus <= d;
        transfer_acknowledge <= 1'h1;
        @(posedge pclk);
        transfer_acknowledge <= 1'h0;
        word(d);
    endtask
    // end of block
    task automatic disconnect();
        controller_disconnect <= 1'h1;
        @(posedge pclk);
        controller_disconnect <= 1'h0;
        @(posedge pclk);
    endtask
endmodule // bus_host_model

//--- bench/converter_io_bus_interface_tb.sv
// testbench: apb, program transfers, control lines, sense, paced block
// assumes the bound checker and the bus host model; one pclk domain
`timescale 1ns/1ps
module converter_io_bus_interface_tb;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, sense_reply;
    logic [31:0]  paddr, pwdata, prdata;
    logic [15:0]  io_bus;
    logic         function_ready_strobe, data_ready_strobe, module_connect_enable;
    logic         controller_connect_request, transfer_acknowledge, controller_disconnect;
    logic         device_ready, connected_acknowledge, transfer_direction, transfer_request;
    logic [7:0]   ext_ctrl_clear, sense_input_n, external_control_output_n, converter_select;
    logic [127:0] converter_data;
    int           bad_count, total_checks;
    localparam logic [5:0] DEV = dac_io_pkg::DEV_ADDR_RST; // our address
    converter_io_bus_interface i_converter_io_bus_interface (.*);
    bus_host_model i_bus_host_model (.*);
    // clock, 100 ns period
    initial
    begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        bad_count += int'(got !== exp);
        if (got !== exp)
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, 24'h000000, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        while (pready !== 1'h1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task automatic rst();
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
    endtask
    // reset values, both registers, a refused offset
    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        chk("ext_out_n", 32'hff, {24'h0, external_control_output_n});
        chk("select", 32'h1, {24'h0, converter_select});
        apb(1'h1, dac_io_pkg::OFF_STATUS, 32'hffff, q, e);
        apb(1'h0, dac_io_pkg::OFF_STATUS, 32'h0, q, e);
        chk("status", 32'h0, q);
        apb(1'h1, dac_io_pkg::OFF_DEV_ADDR, {26'h0, DEV}, q, e);
        apb(1'h0, dac_io_pkg::OFF_DEV_ADDR, 32'h0, q, e);
        chk("dev_addr", {26'h0, DEV}, q);
        apb(1'h0, 8'h0c, 32'h0, q, e);
        chk("unmapped", 32'h1, {31'h0, e});
    endtask
    // every converter: select, load, ungated strobe refused, reuse
    task automatic t_prog();
        logic        r;
        logic [15:0] w;
        for (int i = 0; i < 8; i++)
        begin
            w = 16'hd95a + 16'(i);
            i_bus_host_model.instr(DEV, 3'(i), 7'h40, r);
            i_bus_host_model.instr(DEV, 3'h0, 7'h20, r);
            i_bus_host_model.word(w);
            @(posedge pclk);
            chk("select", 32'h1 << i, {24'h0, converter_select});
            chk("buffer", {16'h0, w}, {16'h0, converter_data[16*i +: 16]});
            i_bus_host_model.word(~w);
            @(posedge pclk);
            chk("ungated", {16'h0, w}, {16'h0, converter_data[16*i +: 16]});
            i_bus_host_model.instr(DEV, 3'h0, 7'h20, r);
            i_bus_host_model.word(w ^ 16'h0ff0);
            @(posedge pclk);
            chk("reuse", {16'h0, w ^ 16'h0ff0}, {16'h0, converter_data[16*i +: 16]});
        end
        chk("ext_out_n", 32'hff, {24'h0, external_control_output_n});
    endtask
    // set each control line; only the clear inputs release them
    task automatic t_ext();
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            i_bus_host_model.instr(DEV, 3'(i), 7'h04, r);
            chk("ext_out_n", {24'h0, 8'hfe << i}, {24'h0, external_control_output_n});
        end
        i_bus_host_model.instr(DEV, 3'h3, 7'h40, r);
        chk("ext_prog", 32'h0, {24'h0, external_control_output_n});
        ext_ctrl_clear <= 8'h0f;
        @(posedge pclk);
        ext_ctrl_clear <= 8'h00;
        repeat (2) @(posedge pclk);
        chk("ext_clear", 32'h0f, {24'h0, external_control_output_n});
    endtask
    // each sense input; low reads true; other address never answers
    task automatic t_sense();
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            i_bus_host_model.instr(DEV, 3'(i), 7'h08, r);
            chk("sense", {31'h0, ~sense_input_n[i]}, {31'h0, r});
        end
        i_bus_host_model.instr(DEV ^ 6'h01, 3'h0, 7'h08, r);
        chk("sense_other", 32'h0, {31'h0, r});
    endtask
    // controller-paced block of two words into converter 2
    task automatic t_block();
        logic r;
        i_bus_host_model.instr(DEV, 3'h2, 7'h40, r);
        i_bus_host_model.instr(DEV ^ 6'h01, 3'h5, 7'h40, r);
        chk("select_other", 32'h4, {24'h0, converter_select});
        i_bus_host_model.connect();
        chk("direction", 32'h1, {31'h0, transfer_direction});
        chk("no_request", 32'h0, {31'h0, transfer_request});
        i_bus_host_model.paced(16'h1234);
        @(posedge pclk);
        chk("block_w0", 32'h1234, {16'h0, converter_data[47:32]});
        i_bus_host_model.paced(16'hfedc);
        @(posedge pclk);
        chk("block_w1", 32'hfedc, {16'h0, converter_data[47:32]});
        chk("held", 32'h1, {31'h0, connected_acknowledge});
        i_bus_host_model.disconnect();
        chk("connected", 32'h0, {31'h0, connected_acknowledge});
    endtask
    // main sequence, ending with a reset in mid-run
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 68'h0;
        ext_ctrl_clear = 8'h00;
        sense_input_n = 8'h5a;
        bad_count = 0;
        total_checks = 0;
        rst();
        t_reset();
        t_prog();
        t_ext();
        t_sense();
        t_block();
        rst();
        chk("ext_out_n", 32'hff, {24'h0, external_control_output_n});
        chk("select", 32'h1, {24'h0, converter_select});
        end_of_test();
    end
endmodule // converter_io_bus_interface_tb
